// ===== bench/dgp_regs_assertions.sv
/* Checker for dgp_regs: read port, gain stages, latency code, patterns.
   Assumes the port timing of the bank; bound to it at the foot. */
`default_nettype none
`timescale 1ns/1ps
module dgp_regs_assertions
(
   // Clock, reset and register port
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // Sample path
   input wire logic [15:0] band0_samp_i,
   input wire logic [15:0] band1_samp_i,
   input wire logic [15:0] wide_samp_i,
   input wire logic wide_mode_i,
   input wire logic [15:0] band0_samp_o,
   input wire logic [15:0] band1_samp_o,
   input wire logic [15:0] wide_samp_o,
   input wire logic [15:0] chan_samp_o,
   input wire logic [2:0] latency_alignment_code_o
);
   logic b0, b1, bw; // Shadow boost bits
   logic [3:0] sel; // Shadow select code
   logic [7:0] pat [4]; // Shadow pattern bytes
   logic wr_pat, mapped;
   logic [15:0] p1w, p2w;
   assign wr_pat = reg_wr_i && reg_addr_i inside {[8'h33:8'h36]};
   assign mapped = reg_addr_i inside {8'h14, 8'h16, 8'h1E, 8'h1F,
      [8'h33:8'h37]};
   assign p1w = {pat[1], pat[0]};
   assign p2w = {pat[3], pat[2]};

   // Shadow registers follow writes like the bank does
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         {b0, b1, bw, sel} <= 7'h00;
         pat <= '{default: 8'h00};
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == 8'h14) b0 <= reg_wdata_i[0];
         if (reg_addr_i == 8'h16) b1 <= reg_wdata_i[0];
         if (reg_addr_i == 8'h1F) bw <= reg_wdata_i[0];
         if (reg_addr_i == 8'h37) sel <= reg_wdata_i[3:0];
         if (wr_pat) pat[2'(reg_addr_i - 8'h33)] <= reg_wdata_i;
      end
   end

   // Saturating doubler; wrap would flip the sign
   function automatic logic [15:0] sc(input logic b, input logic [15:0] x);
      if (!b) return x;
      if (x[15] != x[14]) return x[15] ? 16'h8000 : 16'h7FFF;
      return {x[14:0], 1'b0};
   endfunction : sc

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);

   sequence dbl_held_s;
      (sel == 4'h7 && !wr_pat && p1w != p2w) [*3];
   endsequence
   sequence dbl_swap_s;
      (chan_samp_o == p1w && $past(chan_samp_o) == p2w) ||
      (chan_samp_o == p2w && $past(chan_samp_o) == p1w);
   endsequence

   rdata_idle_a: assert property (
      !reg_rd_i |=> reg_rdata_o == 8'h00) else $error("rdata not idle");
   unmapped_read_a: assert property (
      reg_rd_i && !reg_wr_i && !mapped |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   band0_gain_a: assert property (
      1'b1 |=> band0_samp_o == sc($past(b0), $past(band0_samp_i)))
      else $error("band0 scaling wrong");
   band1_gain_a: assert property (
      1'b1 |=> band1_samp_o == sc($past(b1), $past(band1_samp_i)))
      else $error("band1 scaling wrong");
   wide_gain_a: assert property (
      1'b1 |=> wide_samp_o == sc($past(bw), $past(wide_samp_i)))
      else $error("wide scaling wrong");
   lat_write_a: assert property (
      reg_wr_i && reg_addr_i == 8'h1E |=>
      latency_alignment_code_o == $past(reg_wdata_i[6:4]))
      else $error("latency code wrong");
   zero_pat_a: assert property (
      sel == 4'h1 |=> chan_samp_o == 16'h0000) else $error("zeros wrong");
   ones_pat_a: assert property (
      sel == 4'h2 |=> chan_samp_o == 16'hFFFF) else $error("ones wrong");
   single_pat_a: assert property (
      sel == 4'h6 |=> chan_samp_o == $past(p1w)) else $error("single wrong");
   double_alt_a: assert property (
      dbl_held_s |=> dbl_swap_s) else $error("double not alternating");
endmodule : dgp_regs_assertions
bind dgp_regs dgp_regs_assertions dgp_regs_assertions_i (
   .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .band0_samp_i(band0_samp_i),
   .band1_samp_i(band1_samp_i), .wide_samp_i(wide_samp_i),
   .wide_mode_i(wide_mode_i), .band0_samp_o(band0_samp_o),
   .band1_samp_o(band1_samp_o), .wide_samp_o(wide_samp_o),
   .chan_samp_o(chan_samp_o),
   .latency_alignment_code_o(latency_alignment_code_o));
`default_nettype wire

// ===== bench/dgp_regs_tb.sv
/* Self-checking bench for dgp_regs: registers, gains, patterns.
   Assumes one 125 MHz clock and a sync active-low reset. */
`default_nettype none
`timescale 1ns/1ps
module dgp_regs_tb;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, wmode = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [15:0] s0 = 16'h1234, s1 = 16'h4001, sw = 16'hA000;
   logic [15:0] o0, o1, ow, chan, first;
   logic [2:0] lcode;
   int err_count = 0, check_count = 0, cycles = 0;
   // Register map and readable bits
   logic [7:0] ofs [9] = '{8'h14, 8'h16, 8'h1E, 8'h1F, 8'h33, 8'h34,
      8'h35, 8'h36, 8'h37};
   logic [7:0] msk [9] = '{8'h01, 8'h01, 8'h70, 8'h01, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'h0F};
   logic [7:0] lat [4] = '{8'h10, 8'h20, 8'h40, 8'h50};
   logic [3:0] pc [5] = '{4'h1, 4'h2, 4'h6, 4'h8, 4'h9};
   logic [15:0] pe [5] = '{16'h0000, 16'hFFFF, 16'h1234, 16'hAAAA,
      16'hFFFF};
   logic [3:0] ac [3] = '{4'h3, 4'h7, 4'h4};
   logic [15:0] ea [3] = '{16'hAAAA, 16'h1234, 16'h0000};
   logic [15:0] eb [3] = '{16'h5555, 16'hABCD, 16'h0000};

   dgp_regs dgp_regs_i (.clk_sys_i(clk), .reset_n_i(rst_n),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .band0_samp_i(s0), .band1_samp_i(s1),
      .wide_samp_i(sw), .wide_mode_i(wmode), .band0_samp_o(o0),
      .band1_samp_o(o1), .wide_samp_o(ow), .chan_samp_o(chan),
      .latency_alignment_code_o(lcode));

   always #4 clk = ~clk;

   // Hang guard, well above the expected run
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         test_done();
      end
   end

   task automatic test_done();
      if (err_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: reg %h not %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_smp(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: word %h not %h", $time, got, exp);
      end
   endtask : chk_smp

   // One-cycle write; returns once it has landed
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk_reg(rdata, e);
   endtask : rd_reg

   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      foreach (ofs[i])
      begin
         rd_reg(ofs[i], 8'h00);
         wr_reg(ofs[i], 8'hFF);
         rd_reg(ofs[i], msk[i]);
      end
      wr_reg(8'h15, 8'hFF);
      rd_reg(8'h15, 8'h00);
      foreach (lat[i])
      begin
         wr_reg(8'h1E, lat[i]);
         chk_reg({5'h00, lcode}, lat[i] >> 4);
      end
      for (int i = 0; i < 8; i++)
      begin
         wr_reg(8'h14, {7'h00, i[0]});
         wr_reg(8'h16, {7'h00, i[1]});
         wr_reg(8'h1F, {7'h00, i[2]});
         @(posedge clk);
         #1;
         chk_smp(o0, i[0] ? 16'h2468 : 16'h1234);
         chk_smp(o1, i[1] ? 16'h7FFF : 16'h4001);
         chk_smp(ow, i[2] ? 16'h8000 : 16'hA000);
      end
      wr_reg(8'h33, 8'h34);
      wr_reg(8'h34, 8'h12);
      wr_reg(8'h35, 8'hCD);
      wr_reg(8'h36, 8'hAB);
      rd_reg(8'h36, 8'hAB);
      foreach (pc[i])
      begin
         wr_reg(8'h37, {4'h0, pc[i]});
         repeat (2) @(posedge clk);
         #1;
         chk_smp(chan, pe[i]);
      end
      foreach (ac[i])
      begin
         wr_reg(8'h37, {4'h0, ac[i]});
         repeat (2) @(posedge clk);
         #1;
         first = chan;
         @(posedge clk);
         #1;
         if (ac[i] == 4'h4)
            chk_smp(chan, first + 16'h0001);
         else
         begin
            chk_smp(first, first == ea[i] ? ea[i] : eb[i]);
            chk_smp(chan, first == ea[i] ? eb[i] : ea[i]);
         end
      end
      // Live data: narrowband first, then wideband
      wr_reg(8'h37, 8'h00);
      repeat (3) @(posedge clk);
      #1;
      chk_smp(chan, 16'h2468);
      @(posedge clk);
      wmode <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk_smp(chan, 16'h8000);
      test_done();
   end
endmodule : dgp_regs_tb
`default_nettype wire

// ===== core/dgp_gain_stage.sv
/*
 * One 6 dB gain stage: registers a sample and, when enabled, doubles it
 * with saturation.
 * Assumes: signed two's complement samples on the system clock.
 */
`default_nettype none
`timescale 1ns/1ps
module dgp_gain_stage
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Control
   input wire logic boost_i,
   // Sample path
   input wire logic [dgp_pkg::SAMP_W-1:0] samp_i,
   output logic [dgp_pkg::SAMP_W-1:0] samp_o
);
   // All state of the stage
   typedef struct packed
   {
      logic [dgp_pkg::SAMP_W-1:0] samp;
   } dgp_gain_st_t;

   dgp_gain_st_t st_reg;
   dgp_gain_st_t st_next;

   // Next sample: plain, or doubled and clamped
   always_comb
   begin
      st_next = st_reg;
      if (!boost_i)
      begin
         // Pass through unscaled
         st_next.samp = samp_i;
      end
      // Overflow when the top two bits differ: clamp, never wrap
      else if (samp_i[dgp_pkg::SAMP_W-1] != samp_i[dgp_pkg::SAMP_W-2])
      begin
         st_next.samp = samp_i[dgp_pkg::SAMP_W-1] ?
            {1'b1, {(dgp_pkg::SAMP_W-1){1'b0}}} :
            {1'b0, {(dgp_pkg::SAMP_W-1){1'b1}}};
      end
      else
      begin
         // Times two is a left shift
         st_next.samp = {samp_i[dgp_pkg::SAMP_W-2:0], 1'b0};
      end
   end

   // Register the stage
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign samp_o = st_reg.samp;
endmodule : dgp_gain_stage
`default_nettype wire

// ===== core/dgp_pattern_gen.sv
/*
 * Test pattern generator for one channel word stream.
 * Assumes: select code and custom words come from the register bank
 * on the same clock; one output word per clock.
 */
`default_nettype none
`timescale 1ns/1ps
module dgp_pattern_gen
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Control
   input wire logic [3:0] sel_i,
   input wire logic [dgp_pkg::SAMP_W-1:0] pat_one_i,
   input wire logic [dgp_pkg::SAMP_W-1:0] pat_two_i,
   // Sample path
   input wire logic [dgp_pkg::SAMP_W-1:0] samp_i,
   output logic [dgp_pkg::SAMP_W-1:0] samp_o
);
   // All state: output word, alternation phase, ramp count
   typedef struct packed
   {
      logic [dgp_pkg::SAMP_W-1:0] word;
      logic phase;
      logic [dgp_pkg::SAMP_W-1:0] ramp;
   } dgp_pat_st_t;

   dgp_pat_st_t st_reg;
   dgp_pat_st_t st_next;

   // Pick the output word for the selected pattern
   always_comb
   begin
      st_next = st_reg;
      st_next.phase = ~st_reg.phase;
      st_next.ramp = st_reg.ramp + 16'h0001;
      unique case (sel_i)
         dgp_pkg::PSEL_ZEROS: st_next.word = dgp_pkg::WORD_ZERO;
         dgp_pkg::PSEL_ONES: st_next.word = dgp_pkg::WORD_ONES;
         dgp_pkg::PSEL_TOGGLE: st_next.word = st_reg.phase ?
            dgp_pkg::WORD_TOGGLE_B : dgp_pkg::WORD_TOGGLE_A;
         dgp_pkg::PSEL_RAMP: st_next.word = st_reg.ramp;
         dgp_pkg::PSEL_SINGLE: st_next.word = pat_one_i;
         // Phase 0 gives pattern one, phase 1 pattern two
         dgp_pkg::PSEL_DOUBLE: st_next.word = st_reg.phase ?
            pat_two_i : pat_one_i;
         dgp_pkg::PSEL_DESKEW: st_next.word = dgp_pkg::WORD_DESKEW;
         dgp_pkg::PSEL_SYNC: st_next.word = dgp_pkg::WORD_SYNC;
         // Normal and undefined codes pass live data
         default: st_next.word = samp_i;
      endcase
   end

   // Register the generator
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign samp_o = st_reg.word;
endmodule : dgp_pattern_gen
`default_nettype wire

// ===== core/dgp_pkg.sv
/*
 * Package for the decimation gain and pattern register bank: register
 * offsets, field positions, reset values, pattern select codes and
 * output sample widths.
 * Assumes: an 8-bit register port and 16-bit signed sample words.
 */
`default_nettype none
package dgp_pkg;
   // Register port and sample widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int SAMP_W = 16;

   // Register offsets
   localparam logic [7:0] BAND0_GAIN_OFS = 8'h14;
   localparam logic [7:0] BAND1_GAIN_OFS = 8'h16;
   localparam logic [7:0] LAT_ALIGN_OFS = 8'h1E;
   localparam logic [7:0] WIDE_GAIN_OFS = 8'h1F;
   localparam logic [7:0] PAT1_LO_OFS = 8'h33;
   localparam logic [7:0] PAT1_HI_OFS = 8'h34;
   localparam logic [7:0] PAT2_LO_OFS = 8'h35;
   localparam logic [7:0] PAT2_HI_OFS = 8'h36;
   localparam logic [7:0] PAT_SEL_OFS = 8'h37;

   // Field positions
   localparam int GAIN_BIT = 0;
   localparam int LAT_LSB = 4;
   localparam int LAT_MSB = 6;
   localparam int PSEL_LSB = 0;
   localparam int PSEL_MSB = 3;

   // Reset values
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [15:0] PAT_RESET = 16'h0000;

   // Recommended latency bytes, by complex decimation group
   localparam logic [7:0] LAT_DEC_24_32 = 8'h10;
   localparam logic [7:0] LAT_DEC_16_20 = 8'h20;
   localparam logic [7:0] LAT_DEC_6_12 = 8'h40;
   localparam logic [7:0] LAT_DEC_4_10 = 8'h50;

   // Pattern select codes
   localparam logic [3:0] PSEL_NORMAL = 4'h0;
   localparam logic [3:0] PSEL_ZEROS = 4'h1;
   localparam logic [3:0] PSEL_ONES = 4'h2;
   localparam logic [3:0] PSEL_TOGGLE = 4'h3;
   localparam logic [3:0] PSEL_RAMP = 4'h4;
   localparam logic [3:0] PSEL_SINGLE = 4'h6;
   localparam logic [3:0] PSEL_DOUBLE = 4'h7;
   localparam logic [3:0] PSEL_DESKEW = 4'h8;
   localparam logic [3:0] PSEL_SYNC = 4'h9;

   // Fixed pattern words
   localparam logic [15:0] WORD_ONES = 16'hFFFF;
   localparam logic [15:0] WORD_TOGGLE_A = 16'hAAAA;
   localparam logic [15:0] WORD_TOGGLE_B = 16'h5555;
   localparam logic [15:0] WORD_DESKEW = 16'hAAAA;
   localparam logic [15:0] WORD_SYNC = 16'hFFFF;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
endpackage : dgp_pkg
`default_nettype wire

// ===== core/dgp_regs.sv
/*
 * Decimation gain and pattern register bank with its data path: gain
 * boost for the two narrowband paths and the wideband path, latency
 * alignment code, custom patterns and the channel pattern select.
 * Assumes: register port on the system clock; sample inputs already
 * on the system clock; the filter mode input chooses which path feeds
 * the channel output.
 */
// How it works
// - Band0 bit set doubles band0 output
// - Band1 bit independently doubles band1 output
// - Narrowband bits never touch wideband path
// - Wideband bit set doubles wideband output
// - Wideband bit never touches narrowband paths
// - Two custom patterns, low byte first
// - Select 0001 all zeros, 0010 ones
// - Select 0110 single, 0111 alternating patterns
`default_nettype none
`timescale 1ns/1ps
module dgp_regs
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Register port
   input wire logic [dgp_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [dgp_pkg::DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [dgp_pkg::DATA_W-1:0] reg_rdata_o,
   // Filter samples in
   input wire logic [dgp_pkg::SAMP_W-1:0] band0_samp_i,
   input wire logic [dgp_pkg::SAMP_W-1:0] band1_samp_i,
   input wire logic [dgp_pkg::SAMP_W-1:0] wide_samp_i,
   input wire logic wide_mode_i,
   // Scaled samples out
   output logic [dgp_pkg::SAMP_W-1:0] band0_samp_o,
   output logic [dgp_pkg::SAMP_W-1:0] band1_samp_o,
   output logic [dgp_pkg::SAMP_W-1:0] wide_samp_o,
   // Channel output after pattern select
   output logic [dgp_pkg::SAMP_W-1:0] chan_samp_o,
   // Configuration seen by the filter chain
   output logic [2:0] latency_alignment_code_o
);
   // All register state of the bank
   typedef struct packed
   {
      logic band0_output_gain_boost;
      logic band1_output_gain_boost;
      logic wideband_output_gain_boost;
      logic [2:0] latency_alignment_code;
      logic [dgp_pkg::SAMP_W-1:0] user_pattern_one;
      logic [dgp_pkg::SAMP_W-1:0] user_pattern_two;
      logic [3:0] pattern_sel;
      logic [dgp_pkg::DATA_W-1:0] rdata;
   } dgp_bank_st_t;

   dgp_bank_st_t st_reg;
   dgp_bank_st_t st_next;

   // Gain stage outputs
   logic [dgp_pkg::SAMP_W-1:0] band0_scaled;
   logic [dgp_pkg::SAMP_W-1:0] band1_scaled;
   logic [dgp_pkg::SAMP_W-1:0] wide_scaled;
   // Path feeding the channel pattern generator
   logic [dgp_pkg::SAMP_W-1:0] chan_source;

   // Register writes and the read answer
   always_comb
   begin
      st_next = st_reg;
      // Read data live only in the cycle after a read strobe
      st_next.rdata = '0;
      if (reg_wr_i)
      begin
         // Reserved bits are dropped; software writes them as zero
         // reserved bits ignored
         unique case (reg_addr_i)
            dgp_pkg::BAND0_GAIN_OFS: st_next.band0_output_gain_boost =
               reg_wdata_i[dgp_pkg::GAIN_BIT];
            dgp_pkg::BAND1_GAIN_OFS: st_next.band1_output_gain_boost =
               reg_wdata_i[dgp_pkg::GAIN_BIT];
            dgp_pkg::LAT_ALIGN_OFS: st_next.latency_alignment_code =
               reg_wdata_i[dgp_pkg::LAT_MSB:dgp_pkg::LAT_LSB];
            dgp_pkg::WIDE_GAIN_OFS: st_next.wideband_output_gain_boost =
               reg_wdata_i[dgp_pkg::GAIN_BIT];
            dgp_pkg::PAT1_LO_OFS: st_next.user_pattern_one[7:0] =
               reg_wdata_i;
            dgp_pkg::PAT1_HI_OFS: st_next.user_pattern_one[15:8] =
               reg_wdata_i;
            dgp_pkg::PAT2_LO_OFS: st_next.user_pattern_two[7:0] =
               reg_wdata_i;
            dgp_pkg::PAT2_HI_OFS: st_next.user_pattern_two[15:8] =
               reg_wdata_i;
            dgp_pkg::PAT_SEL_OFS: st_next.pattern_sel =
               reg_wdata_i[dgp_pkg::PSEL_MSB:dgp_pkg::PSEL_LSB];
            // Unmapped addresses take no write
            default: st_next.rdata = '0;
         endcase
      end
      else if (reg_rd_i)
      begin
         // Reserved bits read back as zero
         unique case (reg_addr_i)
            dgp_pkg::BAND0_GAIN_OFS:
               st_next.rdata = {7'h00, st_reg.band0_output_gain_boost};
            dgp_pkg::BAND1_GAIN_OFS:
               st_next.rdata = {7'h00, st_reg.band1_output_gain_boost};
            dgp_pkg::LAT_ALIGN_OFS:
               st_next.rdata = {1'b0, st_reg.latency_alignment_code, 4'h0};
            dgp_pkg::WIDE_GAIN_OFS:
               st_next.rdata = {7'h00, st_reg.wideband_output_gain_boost};
            dgp_pkg::PAT1_LO_OFS: st_next.rdata = st_reg.user_pattern_one[7:0];
            dgp_pkg::PAT1_HI_OFS:
               st_next.rdata = st_reg.user_pattern_one[15:8];
            dgp_pkg::PAT2_LO_OFS: st_next.rdata = st_reg.user_pattern_two[7:0];
            dgp_pkg::PAT2_HI_OFS:
               st_next.rdata = st_reg.user_pattern_two[15:8];
            dgp_pkg::PAT_SEL_OFS: st_next.rdata = {4'h0, st_reg.pattern_sel};
            // Unmapped addresses read as zero
            default: st_next.rdata = '0;
         endcase
      end
   end

   // Register the bank; everything resets to zero
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   // Band0 path, own bit only
   // band0 doubling
   dgp_gain_stage u_band0_gain
   (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .boost_i(st_reg.band0_output_gain_boost),
      .samp_i(band0_samp_i),
      .samp_o(band0_scaled)
   );

   // Band1 path, independent of band0
   // band1 doubling
   dgp_gain_stage u_band1_gain
   (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .boost_i(st_reg.band1_output_gain_boost),
      .samp_i(band1_samp_i),
      .samp_o(band1_scaled)
   );

   // Wideband path sees only its own bit, never the band bits
   // narrowband bits excluded
   dgp_gain_stage u_wide_gain
   (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .boost_i(st_reg.wideband_output_gain_boost),
      .samp_i(wide_samp_i),
      .samp_o(wide_scaled)
   );

   // Channel draws from wideband filter in divide-by-4/6 modes
   assign chan_source = wide_mode_i ? wide_scaled : band0_scaled;

   // Pattern select on the channel stream
   // zeros and ones
   dgp_pattern_gen u_pattern
   (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .sel_i(st_reg.pattern_sel),
      .pat_one_i(st_reg.user_pattern_one),
      .pat_two_i(st_reg.user_pattern_two),
      .samp_i(chan_source),
      .samp_o(chan_samp_o)
   );

   // Outputs, all from flip-flops
   assign band0_samp_o = band0_scaled;
   assign band1_samp_o = band1_scaled;
   assign wide_samp_o = wide_scaled;
   assign reg_rdata_o = st_reg.rdata;
   assign latency_alignment_code_o = st_reg.latency_alignment_code;
endmodule : dgp_regs
`default_nettype wire
